/* hdl/dps_pkg.sv */
// constants shared by the dual-port semaphore RAM host controller
package dps_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int SEM_COUNT = 8;
    localparam int SEM_IDX_W = 3;
    localparam int CLK_PERIOD_NS = 5;
    // write pulse and access times of the slowest grade, in ns
    localparam int WRITE_PULSE_NS = 60;
    localparam int ACCESS_NS = 70;
    localparam int RECOVER_NS = 30;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
    typedef enum logic [1:0] {
        DPS_OP_MEM_RD,
        DPS_OP_MEM_WR,
        DPS_OP_SEM_RD,
        DPS_OP_SEM_WR
    } dps_op_e;
endpackage : dps_pkg

/* hdl/dps_sync.sv */
// two flip-flop synchroniser for the data pins read back from the device
`timescale 1ns/1ps
`default_nettype none
module dps_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end
    assign q_out = sync_reg;
endmodule : dps_sync
`default_nettype wire

/* hdl/dps_host.sv */
// host controller driving one port of the dual-port semaphore RAM
// How it works
// - host drops enables between successive semaphore reads
// - acquire writes zero first, then reads back
// - failed request is read again or released
// - host frees every semaphore after reset
`timescale 1ns/1ps
`default_nettype none
module dps_host (
    // clock and reset
    input  wire logic                        CLK_IN,
    input  wire logic                        RESET_N_IN,
    // user command
    input  wire logic                        CMD_VALID_IN,
    input  wire logic [1:0]                  CMD_OP_IN,
    input  wire logic [dps_pkg::ADDR_W-1:0]  CMD_ADDR_IN,
    input  wire logic [dps_pkg::DATA_W-1:0]  CMD_WDATA_IN,
    output logic                             CMD_READY_OUT,
    output logic                             RSP_VALID_OUT,
    output logic [dps_pkg::DATA_W-1:0]       RSP_RDATA_OUT,
    output logic                             INIT_DONE_OUT,
    // device pins
    output logic                             CE_N_OUT,
    output logic                             SEMAPHORE_SELECT_N_OUT,
    output logic                             OE_N_OUT,
    output logic                             RW_OUT,
    output logic [dps_pkg::ADDR_W-1:0]       ADDR_OUT,
    input  wire logic [dps_pkg::DATA_W-1:0]  DATA_IN,
    output logic [dps_pkg::DATA_W-1:0]       DATA_OUT,
    output logic                             DATA_OE_OUT
);
    typedef enum logic [2:0] {
        DPS_IDLE, DPS_SETUP, DPS_STROBE, DPS_HOLD, DPS_RECOVER
    } dps_state_e;

    logic       rst_meta_reg;
    logic       rst_n_reg;
    dps_state_e state_reg;
    dps_state_e state_next;
    logic [dps_pkg::CNT_W-1:0] cnt_reg;
    logic [dps_pkg::SEM_IDX_W:0] init_idx_reg;
    logic                    initing_reg;
    dps_pkg::dps_op_e        op_reg;
    logic [dps_pkg::ADDR_W-1:0] addr_reg;
    logic [dps_pkg::DATA_W-1:0] wdata_reg;
    logic [dps_pkg::DATA_W-1:0] rdata_reg;
    logic                    rsp_reg;
    logic [dps_pkg::DATA_W-1:0] data_sync;

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    dps_sync #(.W(dps_pkg::DATA_W)) u_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (rst_n_reg),
        .d_in     (DATA_IN),
        .q_out    (data_sync)
    );

    wire is_sem    = (op_reg == dps_pkg::DPS_OP_SEM_RD) || (op_reg == dps_pkg::DPS_OP_SEM_WR);
    wire is_write  = (op_reg == dps_pkg::DPS_OP_MEM_WR) || (op_reg == dps_pkg::DPS_OP_SEM_WR);
    wire active    = (state_reg == DPS_SETUP) || (state_reg == DPS_STROBE)
                  || (state_reg == DPS_HOLD);
    wire strobe    = (state_reg == DPS_STROBE);
    wire accept    = (state_reg == DPS_IDLE) && !initing_reg && CMD_VALID_IN;
    wire init_go   = (state_reg == DPS_IDLE) && initing_reg;
    // init ends only once the last release write has recovered, so the
    // user never sees a response pulse from the start-up writes
    wire init_last = (init_idx_reg == (dps_pkg::SEM_IDX_W+1)'(dps_pkg::SEM_COUNT));
    wire cnt_done  = (cnt_reg == '0);
    wire [dps_pkg::CNT_W-1:0] strobe_len = is_write ?
        dps_pkg::CNT_W'(dps_pkg::WRITE_PULSE_CYC) : dps_pkg::CNT_W'(dps_pkg::ACCESS_CYC + 2);

    // exactly one select while active; neither in idle/recover gives standby
    assign CE_N_OUT               = !(active && !is_sem);
    assign SEMAPHORE_SELECT_N_OUT = !(active && is_sem);
    // read/write goes low only during the strobe; its rise ends the write
    assign RW_OUT        = !(strobe && is_write);
    // output enable only for reads, and dropped between accesses so each
    // semaphore read re-latches a fresh flag value
    assign OE_N_OUT      = !(active && !is_write);
    assign DATA_OE_OUT   = active && is_write;
    assign ADDR_OUT      = addr_reg;
    assign DATA_OUT      = wdata_reg;
    assign CMD_READY_OUT = (state_reg == DPS_IDLE) && !initing_reg;
    assign RSP_VALID_OUT = rsp_reg;
    assign RSP_RDATA_OUT = rdata_reg;
    assign INIT_DONE_OUT = !initing_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DPS_IDLE:    if (accept || init_go) state_next = DPS_SETUP;
            DPS_SETUP:   state_next = DPS_STROBE;
            DPS_STROBE:  if (cnt_done) state_next = DPS_HOLD;
            DPS_HOLD:    state_next = DPS_RECOVER;
            DPS_RECOVER: if (cnt_done) state_next = DPS_IDLE;
            default:     state_next = DPS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= DPS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cnt_reg <= '0;
        end else if (state_reg == DPS_SETUP) begin
            cnt_reg <= strobe_len - 1'b1;
        end else if (state_reg == DPS_HOLD) begin
            cnt_reg <= dps_pkg::CNT_W'(dps_pkg::RECOVER_CYC - 1);
        end else if (!cnt_done) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // after reset every semaphore is written with one so all start free
    always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            initing_reg  <= 1'b1;
            init_idx_reg <= '0;
        end else if (init_go) begin
            init_idx_reg <= init_idx_reg + 1'b1;
        end else if (init_last && (state_reg == DPS_RECOVER) && cnt_done) begin
            initing_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            op_reg    <= dps_pkg::DPS_OP_MEM_RD;
            addr_reg  <= dps_pkg::ADDR_RESET;
            wdata_reg <= dps_pkg::DATA_RESET;
        end else if (init_go) begin
            op_reg    <= dps_pkg::DPS_OP_SEM_WR;
            addr_reg  <= {{(dps_pkg::ADDR_W-dps_pkg::SEM_IDX_W){1'b0}},
                          init_idx_reg[dps_pkg::SEM_IDX_W-1:0]};
            wdata_reg <= 8'h01;
        end else if (accept) begin
            // commands run one at a time in arrival order, so the user's
            // write-then-read acquire and release-after-failure keep their order
            op_reg    <= dps_pkg::dps_op_e'(CMD_OP_IN);
            addr_reg  <= CMD_ADDR_IN;
            wdata_reg <= CMD_WDATA_IN;
        end
    end

    // read data sampled at the end of the strobe, after synchroniser delay
    always_ff @(posedge CLK_IN or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rdata_reg <= dps_pkg::DATA_RESET;
            rsp_reg   <= 1'b0;
        end else begin
            rsp_reg <= (state_reg == DPS_HOLD) && !initing_reg;
            if (strobe && cnt_done && !is_write) begin
                rdata_reg <= data_sync;
            end
        end
    end

    a_select_exclusive: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        !(!CE_N_OUT && !SEMAPHORE_SELECT_N_OUT))
        else $error("both selects active");

    a_oe_drop_between: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        $rose(OE_N_OUT) |-> OE_N_OUT [*2])
        else $error("output enable not dropped between reads");

    // twelve low cycles: the write pulse count at this clock
    sequence s_write_strobe;
        !RW_OUT [*6] ##1 !RW_OUT [*6];
    endsequence
    sequence s_write_end;
        RW_OUT && DATA_OE_OUT && (!CE_N_OUT || !SEMAPHORE_SELECT_N_OUT);
    endsequence
    a_write_pulse: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        $fell(RW_OUT) |-> s_write_strobe ##1 s_write_end)
        else $error("write strobe length or select wrong at its end");

    a_no_drive_on_read: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        !OE_N_OUT |-> !DATA_OE_OUT)
        else $error("host drives pins during read");

    a_init_frees_all: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        (initing_reg && !RW_OUT) |-> (!SEMAPHORE_SELECT_N_OUT && DATA_OUT[0]))
        else $error("init write is not a semaphore release");

    a_init_done_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        $rose(INIT_DONE_OUT) |-> ((state_reg == DPS_IDLE) && !RSP_VALID_OUT))
        else $error("init reported done before last release finished");

    a_standby_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        (state_reg == DPS_IDLE) |-> (CE_N_OUT && SEMAPHORE_SELECT_N_OUT))
        else $error("selects active while idle");

    a_rsp_after_read: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        (state_reg == DPS_HOLD && !is_write && !initing_reg) |=> RSP_VALID_OUT)
        else $error("missing response");

    a_write_rw_low: assert property (@(posedge CLK_IN) disable iff (!rst_n_reg)
        (!RW_OUT) |-> (DATA_OE_OUT && (!CE_N_OUT || !SEMAPHORE_SELECT_N_OUT)))
        else $error("write strobe without select or data");
endmodule : dps_host
`default_nettype wire

/* verification/dps_dev.sv */
// behavioural dual-port semaphore RAM; left port faces the host
`timescale 1ns/1ps
`default_nettype none
module dps_dev (
    // left port
    input  wire logic        ce_n_in,
    input  wire logic        sem_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        rw_in,
    input  wire logic [11:0] a_in,
    input  wire logic [7:0]  d_in,
    output logic      [7:0]  q_out,
    output logic             oe_out,
    // right port, semaphores only
    input  wire logic        r_rw_in,
    input  wire logic [2:0]  r_idx_in,
    input  wire logic        r_d0_in,
    output logic      [7:0]  r_flag_out
);
    logic [7:0] mem [4096];
    // flags start stale: left side holds every token until the host frees them
    logic [7:0] req_l = 8'h00;
    logic [7:0] req_r = 8'hff;
    logic [7:0] own_l = 8'hff;
    logic [7:0] own_r = 8'h00;
    logic [7:0] held  = 8'h00;
    logic [2:0] idx;
    assign idx = a_in[2:0];
    // release before grant, so a pending request takes over at once
    task automatic settle(input logic [2:0] i);
        if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
        if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
        if (!own_l[i] && !own_r[i]) begin
            if (!req_l[i]) own_l[i] = 1'b1;
            else if (!req_r[i]) own_r[i] = 1'b1;
        end
    endtask : settle
    always @(posedge rw_in) begin
        if (ce_n_in && !sem_n_in) begin
            req_l[idx] = d_in[0];
            settle(idx);
        end else if (!ce_n_in && sem_n_in) begin
            mem[a_in] = d_in;
        end
    end
    always @(posedge r_rw_in) begin
        req_r[r_idx_in] = r_d0_in;
        settle(r_idx_in);
    end
    always @(negedge sem_n_in or negedge oe_n_in) begin
        if (!sem_n_in && !oe_n_in) held = {8{~own_l[idx]}};
    end
    assign r_flag_out = ~own_r;
    assign oe_out = !oe_n_in && rw_in && (ce_n_in != sem_n_in);
    assign q_out = sem_n_in ? mem[a_in] : held;
endmodule : dps_dev
`default_nettype wire

/* verification/dps_host_test.sv */
// self-checking bench: host controller against the device model
`timescale 1ns/1ps
`default_nettype none
module dps_host_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        vld = 1'b0;
    logic [1:0]  op = 2'h0;
    logic [11:0] adr = 12'h000;
    logic [7:0]  wd = 8'h00;
    logic        r_rw = 1'b1;
    logic [2:0]  r_idx = 3'h0;
    logic        r_d0 = 1'b1;
    logic        rdy, rv, done, ce_n, sem_n, oe_n, rw, hoe, doe;
    logic [11:0] da;
    logic [7:0]  rd, hq, dq, bus, rf, got, img [16];
    logic [7:0]  junk = 8'h5a;
    int          errors = 0;
    int          tests_run = 0;
    always #2.5 clk = ~clk;
    // undriven pins show a pattern that flips every cycle
    always @(posedge clk) junk <= ~junk;
    assign bus = hoe ? hq : (doe ? dq : junk);
    dps_host dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .CMD_VALID_IN(vld), .CMD_OP_IN(op),
        .CMD_ADDR_IN(adr), .CMD_WDATA_IN(wd), .CMD_READY_OUT(rdy), .RSP_VALID_OUT(rv),
        .RSP_RDATA_OUT(rd), .INIT_DONE_OUT(done), .CE_N_OUT(ce_n), .OE_N_OUT(oe_n),
        .SEMAPHORE_SELECT_N_OUT(sem_n), .RW_OUT(rw), .ADDR_OUT(da), .DATA_IN(bus),
        .DATA_OUT(hq), .DATA_OE_OUT(hoe));
    dps_dev model (.ce_n_in(ce_n), .sem_n_in(sem_n), .oe_n_in(oe_n), .rw_in(rw), .a_in(da),
        .d_in(bus), .q_out(dq), .oe_out(doe), .r_rw_in(r_rw), .r_idx_in(r_idx),
        .r_d0_in(r_d0), .r_flag_out(rf));
    function automatic logic [7:0] flag_byte(input logic mine);
        return mine ? 8'h00 : 8'hff;
    endfunction : flag_byte
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    // one command: valid held until taken, then wait for the response pulse
    task automatic cmd(input logic [1:0] o, input logic [11:0] a, input logic [7:0] w);
        int n;
        n = 0;
        @(posedge clk);
        vld <= 1'b1;
        op <= o;
        adr <= a;
        wd <= w;
        do @(negedge clk); while (rdy !== 1'b1 && ++n < 400);
        @(posedge clk);
        vld <= 1'b0;
        n = 0;
        do @(negedge clk); while (rv !== 1'b1 && ++n < 40);
        check({7'h00, rv}, 8'h01);
        got = rd;
    endtask : cmd
    task automatic rwr(input logic [2:0] i, input logic v);
        @(posedge clk);
        r_idx <= i;
        r_d0 <= v;
        r_rw <= 1'b0;
        @(posedge clk);
        r_rw <= 1'b1;
        // let the right-side write settle before anyone looks at the flags
        @(negedge clk);
    endtask : rwr
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #100_000;
        errors++;
        end_of_test();
    end
    initial begin
        logic [11:0] a, ma [16];
        logic [7:0]  w;
        int          i;
        void'($urandom(32'heb69_b32f));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({6'h00, done, rdy}, 8'h00);
        for (i = 0; i < 8; i++) begin
            a = {9'($urandom), 3'(i)};
            cmd(2'h2, a, 8'($urandom));
            check(got, flag_byte(1'b0));
        end
        check({7'h00, done}, 8'h01);
        for (i = 0; i < 16; i++) begin
            ma[i] = {4'(i), 8'($urandom)};
            img[i] = 8'($urandom);
            cmd(2'h1, ma[i], img[i]);
        end
        for (i = 0; i < 8; i++) begin
            a = {9'($urandom), 3'(i)};
            w = 8'($urandom);
            cmd(2'h3, a, w & 8'hfe);
            cmd(2'h2, a, w);
            check(got, flag_byte(1'b1));
            rwr(3'(i), 1'b0);
            check(rf, 8'hff);
            cmd(2'h3, a ^ 12'hff8, w | 8'h01);
            cmd(2'h2, a, w);
            check(got, flag_byte(1'b0));
            check(rf, ~(8'h01 << i));
            cmd(2'h3, a, 8'h00);
            cmd(2'h2, a, w);
            check(got, flag_byte(1'b0));
            rwr(3'(i), 1'b1);
            cmd(2'h2, a, w);
            check(got, flag_byte(1'b1));
            cmd(2'h3, a, 8'hff);
            cmd(2'h2, a, w);
            check(got, flag_byte(1'b0));
        end
        // right releases in mid-read: the read keeps the value latched at its start
        a = {9'($urandom), 3'h5};
        rwr(3'h5, 1'b0);
        cmd(2'h3, a, 8'h00);
        fork
            cmd(2'h2, a, 8'h00);
            begin
                repeat (12) @(posedge clk);
                rwr(3'h5, 1'b1);
            end
        join
        check(got, flag_byte(1'b0));
        cmd(2'h2, a, 8'h00);
        check(got, flag_byte(1'b1));
        cmd(2'h3, a, 8'h01);
        cmd(2'h2, a, 8'h00);
        check(got, flag_byte(1'b0));
        for (i = 0; i < 16; i++) begin
            cmd(2'h0, ma[i], 8'h00);
            check(got, img[i]);
        end
        end_of_test();
    end
endmodule : dps_host_test
`default_nettype wire
